// *** dv/srwd_host.sv ***
`timescale 1ns/10ps
module srwd_host #(
  parameter int unsigned KICK_GAP = 4
) (
  // Clock.
  input  wire logic clk,
  // Bench controls.
  input  wire logic kick_en,
  input  wire logic loop_alarm,
  input  wire logic loop_warn,
  input  wire logic button_n,
  // Supervisor outputs seen by the host.
  input  wire logic watchdog_alarm_n,
  input  wire logic early_warning_out_n,
  // Lines into the supervisor.
  output logic      watchdog_kick,
  output logic      manual_reset_n
);
  int unsigned cnt_q = 0;
  logic        kick_q = 1'b0;

  // Toggle the kick line every few cycles while the firmware is alive.
  always @(posedge clk) begin
    if (kick_en && cnt_q == KICK_GAP - 1) kick_q <= ~kick_q;
    cnt_q <= (cnt_q == KICK_GAP - 1) ? 0 : cnt_q + 1;
  end
  assign watchdog_kick = kick_q;

  // The button, optionally wired from the alarm or from the warning.
  assign manual_reset_n = button_n & (~loop_alarm | watchdog_alarm_n)
                        & (~loop_warn | early_warning_out_n);
endmodule : srwd_host

// *** dv/tb_supervisor_reset_watchdog.sv ***
`timescale 1ns/10ps
module tb_supervisor_reset_watchdog;
  import srwd_pkg::*;
  localparam int unsigned WL = 64;
  localparam int unsigned RL = 16;
  logic clk = 1'b0, srst = 1'b1, main_ok = 1'b1, aux_a = 1'b1, aux_b = 1'b1;
  logic triple = 1'b0, sense = 1'b1, kick_en = 1'b1, button_n = 1'b1;
  logic loop_alarm = 1'b0, loop_warn = 1'b0;
  srwd_variant_t variant = SRWD_VAR_STANDARD;
  logic kick, mr_n, reset_n, reset, alarm_n, warn_n;
  int n_errors = 0, n_checks = 0, cycles = 0;

  // Free-running clock.
  always #25 clk = ~clk;

  srwd_core #(.WDOG_LIMIT(WL), .RST_LIMIT(RL)) dut (.clk(clk), .srst(srst),
    .variant(variant), .main_supply_ok(main_ok), .aux_supply_a_sense(aux_a),
    .aux_supply_b_sense(aux_b), .triple_monitor(triple), .manual_reset_n(mr_n),
    .watchdog_kick(kick), .early_warning_sense(sense), .reset_n(reset_n),
    .reset(reset), .watchdog_alarm_n(alarm_n), .early_warning_out_n(warn_n));
  srwd_host #(.KICK_GAP(4)) host (.clk(clk), .kick_en(kick_en),
    .loop_alarm(loop_alarm), .loop_warn(loop_warn), .button_n(button_n),
    .watchdog_alarm_n(alarm_n), .early_warning_out_n(warn_n),
    .watchdog_kick(kick), .manual_reset_n(mr_n));

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : go

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  // Reset must hold the full timeout after its cause ends, then let go.
  task automatic end_cond(input string m);
    go(RL);
    chk(reset_n === 1'b0, {m, " released early"});
    go(8);
    chk(reset_n === 1'b1, {m, " not released"});
  endtask : end_cond

  task automatic restart(input srwd_variant_t v);
    srst = 1'b1;
    variant = v;
    go(12);
    srst = 1'b0;
    // No input sync latency here: the timeout runs from the first edge after release.
    go(RL - 1);
    chk(reset_n === 1'b0, "power-up released early");
    go(2);
    chk(reset_n === 1'b1, "power-up not released");
  endtask : restart

  // Waits for one reset pulse, judges the alarm level at its start and its length.
  task automatic pulse(input string m, input logic alm);
    int i;
    for (i = 0; i < WL + 12 && reset_n !== 1'b0; i++) go(1);
    chk(reset_n === 1'b0 && alarm_n === alm, {m, " no pulse"});
    for (i = 0; i < RL + 12 && reset_n === 1'b0; i++) go(1);
    chk(i >= RL && reset_n === 1'b1, {m, " bad length"});
    go(8);
    chk(reset_n === 1'b1, {m, " second pulse"});
  endtask : pulse

  task automatic t_standard();
    kick_en = 1'b0;
    main_ok = 1'b0;
    go(6);
    chk(reset_n === 1'b0 && alarm_n === 1'b0, "brownout");
    main_ok = 1'b1;
    go(8);
    main_ok = 1'b0;
    go(4);
    main_ok = 1'b1;
    end_cond("brownout");
    chk(alarm_n === 1'b0, "alarm freed without kick");
    kick_en = 1'b1;
    go(10);
    chk(alarm_n === 1'b1, "kick did not free alarm");
    kick_en = 1'b0;
    go(WL - 8);
    chk(alarm_n === 1'b1, "early expiry");
    go(16);
    chk(alarm_n === 1'b0 && reset_n === 1'b1, "expiry");
    kick_en = 1'b1;
    button_n = 1'b0;
    go(6);
    chk(reset_n === 1'b0 && alarm_n === 1'b0, "manual reset");
    button_n = 1'b1;
    end_cond("manual");
    sense = 1'b0;
    aux_a = 1'b0;
    go(6);
    chk(warn_n === 1'b0 && reset_n === 1'b1, "warning");
    sense = 1'b1;
    aux_a = 1'b1;
    go(6);
    chk(warn_n === 1'b1, "warning stuck");
    loop_warn = 1'b1;
    sense = 1'b0;
    go(3);
    sense = 1'b1;
    pulse("warning loop", 1'b0);
    loop_warn = 1'b0;
  endtask : t_standard

  task automatic t_triple();
    triple = 1'b1;
    restart(SRWD_VAR_STANDARD);
    aux_b = 1'b0;
    go(6);
    chk(reset_n === 1'b0, "aux low");
    aux_b = 1'b1;
    end_cond("aux");
    triple = 1'b0;
  endtask : t_triple

  task automatic t_latch_release();
    restart(SRWD_VAR_LATCHREL);
    kick_en = 1'b0;
    main_ok = 1'b0;
    go(6);
    chk(alarm_n === 1'b0, "uv alarm");
    main_ok = 1'b1;
    go(6);
    chk(alarm_n === 1'b1, "uv alarm held");
    go(RL + 4);
    go(WL + 8);
    chk(alarm_n === 1'b0, "expiry");
    button_n = 1'b0;
    go(6);
    chk(alarm_n === 1'b1, "manual did not clear");
    button_n = 1'b1;
    end_cond("manual");
    loop_alarm = 1'b1;
    pulse("alarm loop", 1'b1);
    loop_alarm = 1'b0;
  endtask : t_latch_release

  // Active-high reset always mirrors the active-low one.
  always @(negedge clk) if (!srst) chk(reset === ~reset_n, "complement");

  // Hang guard.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    restart(SRWD_VAR_STANDARD);
    t_standard();
    t_triple();
    t_latch_release();
    restart(SRWD_VAR_RSTBASED);
    kick_en = 1'b0;
    pulse("reset-based", 1'b1);
    summarize();
  end
endmodule : tb_supervisor_reset_watchdog

// *** inc/srwd_pkg.sv ***
package srwd_pkg;

  // Clock rate and documented times.
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned WDOG_PERIOD_MS   = 1600;
  localparam int unsigned RST_TIMEOUT_MS   = 140;

  // Timer lengths in clock cycles; the reset timeout is the exact minimum.
  localparam int unsigned WDOG_CYCLES = (CLK_HZ / 1000) * WDOG_PERIOD_MS;
  localparam int unsigned RST_CYCLES  = ((CLK_HZ / 1000) * RST_TIMEOUT_MS);

  // Counter widths.
  localparam int unsigned CNT_W = 32;

  // Variant codes.
  typedef enum logic [1:0] {
    SRWD_VAR_STANDARD = 2'h0,
    SRWD_VAR_LATCHREL = 2'h1,
    SRWD_VAR_RSTBASED = 2'h2
  } srwd_variant_t;

endpackage : srwd_pkg

// *** logic/srwd_core.sv ***
`timescale 1ns/10ps
module srwd_core #(
  parameter int unsigned WDOG_LIMIT = srwd_pkg::WDOG_CYCLES,
  parameter int unsigned RST_LIMIT  = srwd_pkg::RST_CYCLES
) (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Variant selection, held static.
  input  wire srwd_pkg::srwd_variant_t variant,
  // Supply-good indications, high when above threshold, and the triple-monitor enable.
  input  wire logic                   main_supply_ok,
  input  wire logic                   aux_supply_a_sense,
  input  wire logic                   aux_supply_b_sense,
  input  wire logic                   triple_monitor,
  // Host-side inputs.
  input  wire logic                   manual_reset_n,
  input  wire logic                   watchdog_kick,
  input  wire logic                   early_warning_sense,
  // Outputs to the host.
  output logic                        reset_n,
  output logic                        reset,
  output logic                        watchdog_alarm_n,
  output logic                        early_warning_out_n
);
  import srwd_pkg::*;

  logic main_s;
  logic aux_a_s;
  logic aux_b_s;
  logic mr_s;
  logic kick_s;
  logic pf_s;
  logic [2:0] raw_in;
  logic [2:0] sync_vec;

  // Synchronise the main supply, manual-reset and early-warning levels before use.
  assign raw_in = {main_supply_ok, manual_reset_n, early_warning_sense};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      srwd_sync u_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (raw_in[gi]),
        .sync_out (sync_vec[gi])
      );
    end
  endgenerate
  assign {main_s, mr_s, pf_s} = sync_vec;

  logic [1:0] aux_m_q;
  logic [1:0] aux_m_d;
  logic [1:0] aux_s_q;
  logic [1:0] aux_s_d;
  logic       kick_m_q;
  logic       kick_m_d;
  logic       kick_s_q;
  logic       kick_s_d;
  logic       kick_p_q;
  logic       kick_p_d;

  // Aux supplies and kick through two flops; kick edges from last two samples.
  always_comb begin
    aux_m_d  = {aux_supply_b_sense, aux_supply_a_sense};
    aux_s_d  = aux_m_q;
    kick_m_d = watchdog_kick;
    kick_s_d = kick_m_q;
    kick_p_d = kick_s_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aux_m_q  <= 2'h3;
      aux_s_q  <= 2'h3;
      kick_m_q <= 1'h0;
      kick_s_q <= 1'h0;
      kick_p_q <= 1'h0;
    end else begin
      aux_m_q  <= aux_m_d;
      aux_s_q  <= aux_s_d;
      kick_m_q <= kick_m_d;
      kick_s_q <= kick_s_d;
      kick_p_q <= kick_p_d;
    end
  end

  assign aux_a_s = aux_s_q[0];
  assign aux_b_s = aux_s_q[1];
  assign kick_s  = kick_s_q;

  logic kick_edge;
  logic undervolt;
  assign kick_edge = kick_s ^ kick_p_q;
  // Aux inputs count only while the triple-monitor enable is set, in any variant.
  assign undervolt = !main_s || (triple_monitor && (!aux_a_s || !aux_b_s));

  // Reset timeout and watchdog timer.
  logic [CNT_W-1:0] rcnt_q;
  logic [CNT_W-1:0] rcnt_d;
  logic [CNT_W-1:0] wcnt_q;
  logic [CNT_W-1:0] wcnt_d;
  logic             rst_act_q;
  logic             rst_act_d;
  logic             alarm_q;
  logic             alarm_d;
  logic             wdog_expire;
  logic             rst_cond;
  logic             latch_rel;

  assign latch_rel   = (variant == SRWD_VAR_LATCHREL);
  assign wdog_expire = !rst_act_q && (wcnt_q == CNT_W'(WDOG_LIMIT - 1));
  // Any reset source; watchdog only in the reset-based variant.
  assign rst_cond = undervolt || !mr_s
                    || (wdog_expire && (variant == SRWD_VAR_RSTBASED));

  // Reset pulse: asserted while a condition holds, then RST_LIMIT cycles more.
  always_comb begin
    rst_act_d = rst_act_q;
    rcnt_d    = rcnt_q;
    if (rst_cond) begin
      rst_act_d = 1'h1;
      rcnt_d    = '0;
    end else if (rst_act_q) begin
      if (rcnt_q == CNT_W'(RST_LIMIT - 1)) begin
        rst_act_d = 1'h0;
        rcnt_d    = '0;
      end else begin
        rcnt_d = rcnt_q + CNT_W'(1);
      end
    end
  end

  // Watchdog timer: cleared by reset, manual reset, a kick edge, or its own expiry.
  always_comb begin
    if (rst_act_q || rst_cond || !mr_s || kick_edge || wdog_expire) begin
      wcnt_d = '0;
    end else begin
      wcnt_d = wcnt_q + CNT_W'(1);
    end
  end

  // Alarm latch.
  always_comb begin
    alarm_d = alarm_q;
    if (variant == SRWD_VAR_RSTBASED) begin
      alarm_d = 1'h0;
    end else if (latch_rel) begin
      if (!mr_s || kick_edge) begin
        alarm_d = 1'h0;
      end
      if (wdog_expire) begin
        alarm_d = 1'h1;
      end
    end else begin
      if (kick_edge) begin
        alarm_d = 1'h0;
      end
      if (wdog_expire || undervolt || !mr_s) begin
        alarm_d = 1'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rst_act_q <= 1'h1;
      rcnt_q    <= '0;
      wcnt_q    <= '0;
      alarm_q   <= 1'h0;
    end else begin
      rst_act_q <= rst_act_d;
      rcnt_q    <= rcnt_d;
      wcnt_q    <= wcnt_d;
      alarm_q   <= alarm_d;
    end
  end

  logic out_rst_q;
  logic out_rst_d;
  logic out_alm_q;
  logic out_alm_d;
  logic out_pf_q;
  logic out_pf_d;

  // Output flops; undervolt forces reset, and alarm too outside the reset-based variant, in the same cycle.
  always_comb begin
    out_rst_d = rst_act_d;
    out_alm_d = (variant != SRWD_VAR_RSTBASED) && (alarm_d || undervolt);
    out_pf_d  = !pf_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_rst_q <= 1'h1;
      out_alm_q <= 1'h0;
      out_pf_q  <= 1'h0;
    end else begin
      out_rst_q <= out_rst_d;
      out_alm_q <= out_alm_d;
      out_pf_q  <= out_pf_d;
    end
  end

  assign reset_n             = !out_rst_q;
  assign reset               = out_rst_q;
  assign watchdog_alarm_n    = !out_alm_q;
  assign early_warning_out_n = !out_pf_q;

  // Undervoltage brings reset and alarm in the same cycle, outside the reset-based variant.
  property p_uv_both;
    @(posedge clk) disable iff (srst)
      (undervolt && variant != SRWD_VAR_RSTBASED) |=> (!reset_n && !watchdog_alarm_n);
  endproperty
  a_uv_both: assert property (p_uv_both) else $error("alarm and reset not together");

  property p_uv_alarm;
    @(posedge clk) disable iff (srst)
      (undervolt && variant != SRWD_VAR_RSTBASED) |=> !watchdog_alarm_n;
  endproperty
  a_uv_alarm: assert property (p_uv_alarm) else $error("alarm high in undervoltage");

  property p_no_alarm_rb;
    @(posedge clk) disable iff (srst)
      (variant == SRWD_VAR_RSTBASED) |=> watchdog_alarm_n;
  endproperty
  a_no_alarm_rb: assert property (p_no_alarm_rb) else $error("alarm in reset variant");

  property p_pf;
    @(posedge clk) disable iff (srst) !pf_s |=> !early_warning_out_n;
  endproperty
  a_pf: assert property (p_pf) else $error("early warning missing");

  property p_compl;
    @(posedge clk) disable iff (srst) reset == !reset_n;
  endproperty
  a_compl: assert property (p_compl) else $error("reset pair not complement");

  property p_mr;
    @(posedge clk) disable iff (srst) !mr_s |=> !reset_n;
  endproperty
  a_mr: assert property (p_mr) else $error("manual reset ignored");

  sequence s_cond_end;
    rst_cond ##1 !rst_cond;
  endsequence
  property p_hold;
    @(posedge clk) disable iff (srst) s_cond_end |-> !reset_n [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset released early");

  property p_wclr;
    @(posedge clk) disable iff (srst) (kick_edge || rst_act_q) |=> (wcnt_q == '0);
  endproperty
  a_wclr: assert property (p_wclr) else $error("watchdog not cleared");

  property p_mr_clr;
    @(posedge clk) disable iff (srst)
      (latch_rel && !mr_s && !undervolt && !wdog_expire) |=> ##1 watchdog_alarm_n;
  endproperty
  a_mr_clr: assert property (p_mr_clr) else $error("alarm not cleared");

endmodule : srwd_core

// *** logic/srwd_sync.sv ***
`timescale 1ns/10ps
module srwd_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_in,
  output logic      sync_out
);
  import srwd_pkg::*;

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // Two-stage capture; the first stage feeds only the second.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'h1;
      sync_q <= 1'h1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : srwd_sync
